// >>> hdl/scio_consts.svh
// Offsets, field positions, reset values and timing counts of the support block
`ifndef SCIO_CONSTS_SVH
`define SCIO_CONSTS_SVH

// Register byte offsets
`define SCIO_OFS_SENSE 8'h00
`define SCIO_OFS_DRIVE 8'h04
`define SCIO_OFS_EXPORT 8'h08
`define SCIO_OFS_SOFT_RESET 8'h0c
`define SCIO_OFS_STATUS 8'h10

// Field positions in the export control register
`define SCIO_EXP_ON_BIT 0
`define SCIO_EXP_CHAN_LSB 4
`define SCIO_EXP_CHAN_MSB 7
`define SCIO_EXP_LAG_LSB 8
`define SCIO_EXP_LAG_MSB 11

// Field positions in the status register
`define SCIO_STAT_BUSY_BIT 0
`define SCIO_STAT_GPSEL_LSB 4
`define SCIO_STAT_GPSEL_MSB 6

// Reset values
`define SCIO_DRIVE_RST 12'h000
`define SCIO_EXPORT_RST 9'h000

// Port widths and export pin positions
`define SCIO_SENSE_W 20
`define SCIO_DRIVE_W 12
`define SCIO_MARK_BIT 11
`define SCIO_SEQ_BIT 10

// Timing in core clock cycles
`define SCIO_RECOG_CYCLES 3
`define SCIO_INIT_CYCLES 32
`define SCIO_LAG_BASE 3
`define SCIO_LAG_TAPS 16

`endif

// >>> hdl/scio_pkg.sv
// Types and the divider decode shared by the support block files
`default_nettype none

package scio_pkg;

  // One channel's code and control signals
  typedef struct packed {
    logic chip;
    logic epoch;
  } scio_code_ctrl_t;

  // Export control fields
  typedef struct packed {
    logic [3:0] lag;
    logic [3:0] chan;
    logic on;
  } scio_export_ctrl_t;

  // Reset sequencer states
  typedef enum logic [1:0] {
    SCIO_RUN = 2'b00,
    SCIO_PEND = 2'b01,
    SCIO_HOLD = 2'b10
  } scio_rst_state_t;

  // Select code 0 disables, codes 1..7 divide by 2..8
  function automatic logic [3:0] scio_factor(input logic [2:0] sel);
    scio_factor = (sel == 3'h0) ? 4'h0 : ({1'b0, sel} + 4'h1);
  endfunction : scio_factor

endpackage : scio_pkg

`default_nettype wire

// >>> hdl/scio_gpclk_div.sv
// General-purpose clock divider driven by master clock edge ticks
`timescale 1ns/1ps
`default_nettype none

module scio_gpclk_div (
  input wire logic clock,
  input wire logic rst,
  input wire logic tick,
  input wire logic [2:0] sel,
  output logic gp_clk_r
);

  logic [3:0] factor;
  logic [3:0] high_len;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;

  // Half period rounded up gives the extra high period on odd factors
  assign factor = scio_pkg::scio_factor(sel);
  assign high_len = (factor + 4'h1) >> 1;

  // Phase counter wraps at factor minus one
  always_comb begin
    if (cnt_r == 3'(factor - 4'h1)) begin
      cnt_nxt = 3'h0;
    end else begin
      cnt_nxt = cnt_r + 3'h1;
    end
  end

  // Counter and output advance only on master clock ticks
  always_ff @(posedge clock) begin
    if (rst || factor == 4'h0) begin
      cnt_r <= 3'h0;
      gp_clk_r <= 1'b0;
    end else if (tick) begin
      cnt_r <= cnt_nxt;
      gp_clk_r <= ({1'b0, cnt_nxt} < high_len);
    end
  end

endmodule : scio_gpclk_div

`default_nettype wire

// >>> hdl/scio_top.sv
// Clock, reset and parallel port support block with code export
//
// The address map and strobed register access were chosen for this implementation.
`include "scio_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module scio_top #(
  parameter int NCH = 12
) (
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Clock generation
  input wire logic master_clock_pin,
  input wire logic [2:0] gp_divide_select,
  output logic general_purpose_clock_out,
  // Resets toward the rest of the chip
  output logic internal_reset_tree,
  output logic timebase_reset,
  output logic init_busy,
  // Parallel ports
  input wire logic [`SCIO_SENSE_W-1:0] parallel_sense_lines,
  output logic [`SCIO_DRIVE_W-1:0] parallel_drive_lines,
  // Per-channel code and epoch from the channel matrix
  input wire scio_pkg::scio_code_ctrl_t [NCH-1:0] channel_code_ctrl_bus
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic mclk_s1_r;
  logic mclk_s2_r;
  logic mclk_s3_r;
  logic mclk_tick;
  logic [2:0] gpsel_s1_r;
  logic [2:0] gpsel_s2_r;
  logic [`SCIO_SENSE_W-1:0] sense_s1_r;
  logic [`SCIO_SENSE_W-1:0] sense_s2_r;

  scio_pkg::scio_rst_state_t rst_state_r;
  logic [5:0] rst_cnt_r;
  logic soft_req;
  logic core_rst_r;
  logic hard_rst_r;
  logic busy_r;

  logic wr_ok;
  logic rd_ok;
  logic [`SCIO_DRIVE_W-1:0] drive_reg_r;
  scio_pkg::scio_export_ctrl_t export_r;
  logic [31:0] rdata_nxt;

  logic sel_chip_r;
  logic sel_epoch_r;
  logic [`SCIO_LAG_TAPS-1:0] lag_line_r;
  logic [`SCIO_DRIVE_W-1:0] drive_nxt;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------

  // Master clock pin sampled as data; third stage feeds the edge detect
  always_ff @(posedge clock) begin
    if (rst) begin
      mclk_s1_r <= 1'b0;
      mclk_s2_r <= 1'b0;
      mclk_s3_r <= 1'b0;
    end else begin
      mclk_s1_r <= master_clock_pin;
      mclk_s2_r <= mclk_s1_r;
      mclk_s3_r <= mclk_s2_r;
    end
  end

  // Rising edge of master clock; needs core clock above twice its rate
  assign mclk_tick = mclk_s2_r & ~mclk_s3_r;

  // Static divider select; resynchronised so a pin change cannot glitch it
  always_ff @(posedge clock) begin
    if (rst) begin
      gpsel_s1_r <= 3'h0;
      gpsel_s2_r <= 3'h0;
    end else begin
      gpsel_s1_r <= gp_divide_select;
      gpsel_s2_r <= gpsel_s1_r;
    end
  end

  // Sense lines pass two stages, still free running, never held
  always_ff @(posedge clock) begin
    if (rst) begin
      sense_s1_r <= '0;
      sense_s2_r <= '0;
    end else begin
      sense_s1_r <= parallel_sense_lines;
      sense_s2_r <= sense_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // General-purpose clock divider
  // ---------------------------------------------------------------

  // Only the hardware reset reaches it, keeping the clock alive on soft reset
  scio_gpclk_div u_gpclk (
    .clock(clock),
    .rst(rst),
    .tick(mclk_tick),
    .sel(gpsel_s2_r),
    .gp_clk_r(general_purpose_clock_out)
  );

  // ---------------------------------------------------------------
  // Reset sequencer
  // ---------------------------------------------------------------

  // Any write to the soft reset offset in the run state, data ignored
  assign soft_req = reg_wr && (reg_addr == `SCIO_OFS_SOFT_RESET)
                    && (rst_state_r == scio_pkg::SCIO_RUN);

  // Pending phase models recognition delay, hold phase covers init
  always_ff @(posedge clock) begin
    if (rst) begin
      rst_state_r <= scio_pkg::SCIO_HOLD;
      rst_cnt_r <= 6'(`SCIO_INIT_CYCLES - 1);
    end else begin
      case (rst_state_r)
        scio_pkg::SCIO_RUN: begin
          if (soft_req) begin
            rst_state_r <= scio_pkg::SCIO_PEND;
            rst_cnt_r <= 6'(`SCIO_RECOG_CYCLES - 1);
          end
        end
        scio_pkg::SCIO_PEND: begin
          if (rst_cnt_r == 6'h00) begin
            rst_state_r <= scio_pkg::SCIO_HOLD;
            rst_cnt_r <= 6'(`SCIO_INIT_CYCLES - 1);
          end else begin
            rst_cnt_r <= rst_cnt_r - 6'h01;
          end
        end
        scio_pkg::SCIO_HOLD: begin
          if (rst_cnt_r == 6'h00) begin
            rst_state_r <= scio_pkg::SCIO_RUN;
          end else begin
            rst_cnt_r <= rst_cnt_r - 6'h01;
          end
        end
        default: begin
          rst_state_r <= scio_pkg::SCIO_HOLD;
          rst_cnt_r <= 6'(`SCIO_INIT_CYCLES - 1);
        end
      endcase
    end
  end

  // Internal reset in hold and during the hard reset itself
  always_ff @(posedge clock) begin
    if (rst) begin
      core_rst_r <= 1'b1;
    end else begin
      // Drops one cycle before busy so init always outlasts the reset itself
      core_rst_r <= (rst_state_r == scio_pkg::SCIO_PEND && rst_cnt_r == 6'h00)
                    || (rst_state_r == scio_pkg::SCIO_HOLD && rst_cnt_r > 6'h01);
    end
  end

  // Timebase dividers see only the hardware reset
  always_ff @(posedge clock) begin
    hard_rst_r <= rst;
  end

  // Busy flag follows the sequencer so software can poll it after init
  always_ff @(posedge clock) begin
    if (rst) begin
      busy_r <= 1'b1;
    end else begin
      // Raised by the soft reset write itself so a follow-up access is refused
      busy_r <= soft_req || ((rst_state_r != scio_pkg::SCIO_RUN) && !(rst_state_r ==
                scio_pkg::SCIO_HOLD && rst_cnt_r == 6'h00));
    end
  end

  assign internal_reset_tree = core_rst_r;
  assign timebase_reset = hard_rst_r;
  assign init_busy = busy_r;

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------

  // Accesses during reset or init are dropped rather than corrupting state
  assign wr_ok = reg_wr && !busy_r && !core_rst_r;
  assign rd_ok = reg_rd && !busy_r && !core_rst_r;

  // Output port register
  always_ff @(posedge clock) begin
    if (rst || core_rst_r) begin
      drive_reg_r <= `SCIO_DRIVE_RST;
    end else if (wr_ok && reg_addr == `SCIO_OFS_DRIVE) begin
      drive_reg_r <= reg_wdata[`SCIO_DRIVE_W-1:0];
    end
  end

  // Export control register
  always_ff @(posedge clock) begin
    if (rst || core_rst_r) begin
      export_r <= `SCIO_EXPORT_RST;
    end else if (wr_ok && reg_addr == `SCIO_OFS_EXPORT) begin
      export_r.on <= reg_wdata[`SCIO_EXP_ON_BIT];
      export_r.chan <= reg_wdata[`SCIO_EXP_CHAN_MSB:`SCIO_EXP_CHAN_LSB];
      export_r.lag <= reg_wdata[`SCIO_EXP_LAG_MSB:`SCIO_EXP_LAG_LSB];
    end
  end

  // Read multiplexer; unmapped offsets and the soft reset offset read zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (rd_ok) begin
      case (reg_addr)
        `SCIO_OFS_SENSE: begin
          rdata_nxt[`SCIO_SENSE_W-1:0] = sense_s2_r;
        end
        `SCIO_OFS_DRIVE: begin
          rdata_nxt[`SCIO_DRIVE_W-1:0] = drive_reg_r;
        end
        `SCIO_OFS_EXPORT: begin
          rdata_nxt[`SCIO_EXP_ON_BIT] = export_r.on;
          rdata_nxt[`SCIO_EXP_CHAN_MSB:`SCIO_EXP_CHAN_LSB] = export_r.chan;
          rdata_nxt[`SCIO_EXP_LAG_MSB:`SCIO_EXP_LAG_LSB] = export_r.lag;
        end
        `SCIO_OFS_STATUS: begin
          rdata_nxt[`SCIO_STAT_BUSY_BIT] = busy_r;
          rdata_nxt[`SCIO_STAT_GPSEL_MSB:`SCIO_STAT_GPSEL_LSB] = gpsel_s2_r;
        end
        default: begin
          rdata_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Code export path
  // ---------------------------------------------------------------

  // Channel pick registered; out-of-range channel selects give zeros
  always_ff @(posedge clock) begin
    if (rst || core_rst_r) begin
      sel_chip_r <= 1'b0;
      sel_epoch_r <= 1'b0;
    end else if (int'(export_r.chan) < NCH) begin
      sel_chip_r <= channel_code_ctrl_bus[export_r.chan].chip;
      sel_epoch_r <= channel_code_ctrl_bus[export_r.chan].epoch;
    end else begin
      sel_chip_r <= 1'b0;
      sel_epoch_r <= 1'b0;
    end
  end

  // Delay line; tap index is the lag field, base delay added by the pipe
  always_ff @(posedge clock) begin
    if (rst || core_rst_r) begin
      lag_line_r <= '0;
    end else begin
      lag_line_r <= {lag_line_r[`SCIO_LAG_TAPS-2:0], sel_chip_r};
    end
  end

  // Top two pins switch source; register bits otherwise pass straight on
  always_comb begin
    drive_nxt = drive_reg_r;
    if (export_r.on) begin
      drive_nxt[`SCIO_MARK_BIT] = ~sel_epoch_r;
      drive_nxt[`SCIO_SEQ_BIT] = lag_line_r[export_r.lag];
    end
  end

  // Pin register: marker two cycles, sequence lag plus three cycles
  always_ff @(posedge clock) begin
    if (rst || core_rst_r) begin
      parallel_drive_lines <= `SCIO_DRIVE_RST;
    end else begin
      parallel_drive_lines <= drive_nxt;
    end
  end

endmodule : scio_top

`default_nettype wire

// >>> dv/scio_top_asserts.sv
// Port-level assertions for the support block
`timescale 1ns/1ps
`default_nettype none

module scio_top_asserts #(
  parameter int NCH = 12
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic master_clock_pin,
  input wire logic [2:0] gp_divide_select,
  input wire logic general_purpose_clock_out,
  input wire logic internal_reset_tree,
  input wire logic timebase_reset,
  input wire logic init_busy,
  input wire logic [19:0] parallel_sense_lines,
  input wire logic [11:0] parallel_drive_lines,
  input wire scio_pkg::scio_code_ctrl_t [NCH-1:0] channel_code_ctrl_bus
);
  // Accesses the block takes; soft reset writes among them
  wire free = !init_busy && !internal_reset_tree;
  wire soft_wr = reg_wr && reg_addr == 8'h0c && free;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // Hard reset must not be masked by its own disable
  a_hard_reset: assert property (disable iff (1'b0) rst ##1 rst |=>
    internal_reset_tree && init_busy && timebase_reset && parallel_drive_lines == 12'h000
    && !general_purpose_clock_out) else $error("hard reset left state active");
  a_soft_fires: assert property (soft_wr |-> ##[1:5] internal_reset_tree)
    else $error("soft reset not recognised in time");
  a_soft_busy: assert property (soft_wr |=> init_busy [*4])
    else $error("busy missing after soft reset write");
  a_soft_exempt: assert property (soft_wr |=> !timebase_reset [*8])
    else $error("soft reset reached the exempt dividers");
  a_init_tail: assert property ($fell(internal_reset_tree) |-> init_busy ##[0:4] !init_busy)
    else $error("init window wrong at reset end");
  a_busy_lock: assert property (internal_reset_tree && reg_wr |->
    ##2 parallel_drive_lines[9:0] == 10'h000) else $error("write taken during reset");
  a_drive_pins: assert property (reg_wr && reg_addr == 8'h04 && free |->
    ##2 parallel_drive_lines[9:0] == $past(reg_wdata[9:0], 2)) else $error("drive pins wrong");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  a_sense_live: assert property (reg_rd && reg_addr == 8'h00 && free
    && $stable(parallel_sense_lines) && parallel_sense_lines == $past(parallel_sense_lines, 2)
    |=> reg_rdata == {12'h000, $past(parallel_sense_lines)}) else $error("sense read wrong");
  a_gp_off: assert property ((gp_divide_select == 3'h0) [*8] |=> !general_purpose_clock_out)
    else $error("gp clock runs while disabled");

  c_soft: cover property (soft_wr);
  c_gp_rise: cover property ($rose(general_purpose_clock_out));
  c_init_end: cover property ($fell(init_busy));
endmodule : scio_top_asserts

bind scio_top scio_top_asserts #(.NCH(NCH)) u_chk (.clock(clock), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .master_clock_pin(master_clock_pin),
  .gp_divide_select(gp_divide_select), .general_purpose_clock_out(general_purpose_clock_out),
  .internal_reset_tree(internal_reset_tree), .timebase_reset(timebase_reset),
  .init_busy(init_busy), .parallel_sense_lines(parallel_sense_lines),
  .parallel_drive_lines(parallel_drive_lines), .channel_code_ctrl_bus(channel_code_ctrl_bus));

`default_nettype wire

// >>> dv/scio_far_side.sv
// Far-side model: master clock source and channel code streams
`timescale 1ns/1ps
`default_nettype none

module scio_far_side #(
  parameter int NCH = 12
) (
  input wire logic clock,
  output logic master_clock_pin,
  output var scio_pkg::scio_code_ctrl_t [NCH-1:0] channel_code_ctrl_bus
);
  logic [2:0] ph_r = 3'h0;
  logic [6:0] cnt_r = 7'h0;

  // Free-running sources, untouched by the block's resets
  always_ff @(posedge clock) begin
    ph_r <= (ph_r == 3'h5) ? 3'h0 : ph_r + 3'h1;
    cnt_r <= cnt_r + 7'h1;
  end

  // Six core cycles per master period keeps the pin well under half core rate
  assign master_clock_pin = ph_r > 3'h2;

  // Chips last 32 cycles, so every lag up to 18 stays inside one chip
  always_comb begin
    for (int k = 0; k < NCH; k++) begin
      channel_code_ctrl_bus[k].chip = cnt_r[5] ^ k[0] ^ k[1];
      channel_code_ctrl_bus[k].epoch = cnt_r == 7'(k * 9);
    end
  end
endmodule : scio_far_side

`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for the support block
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] gp_divide_select = 3'h1;
  logic [19:0] sense = 20'h00000;
  logic [31:0] reg_rdata;
  logic master_clock_pin;
  logic gp_out;
  logic tree;
  logic tb_rst;
  logic busy;
  logic [11:0] drive;
  scio_pkg::scio_code_ctrl_t [11:0] bus;
  scio_pkg::scio_code_ctrl_t [11:0] hist [0:19];
  logic [31:0] rv;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;

  always #5 clock = ~clock;

  scio_far_side #(.NCH(12)) far (.clock(clock), .master_clock_pin(master_clock_pin),
    .channel_code_ctrl_bus(bus));
  scio_top #(.NCH(12)) dut (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .master_clock_pin(master_clock_pin), .gp_divide_select(gp_divide_select),
    .general_purpose_clock_out(gp_out), .internal_reset_tree(tree), .timebase_reset(tb_rst),
    .init_busy(busy), .parallel_sense_lines(sense), .parallel_drive_lines(drive),
    .channel_code_ctrl_bus(bus));

  // Bus history, entry d-1 holds the value seen d cycles back; cycle ceiling
  always @(posedge clock) begin
    hist[0] <= bus;
    for (int i = 1; i < 20; i++) hist[i] <= hist[i-1];
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic close_out();
    if (bad_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    rv = reg_rdata;
  endtask : rd

  // Wait out init, counting busy cycles and gp clock rises meanwhile
  task automatic idle(output int n, output int rises);
    logic p;
    n = 0;
    rises = 0;
    p = gp_out;
    do begin
      @(posedge clock);
      n++;
      if (gp_out === 1'b1 && p === 1'b0) rises++;
      p = gp_out;
    end while (busy !== 1'b0 && n < 300);
    chk("idle", busy, 32'h0);
  endtask : idle

  task automatic run(input logic v, inout int w, output int len);
    len = 0;
    while (gp_out === v && w < 400) begin
      @(posedge clock);
      w++;
      len++;
    end
  endtask : run

  task automatic gp_meas(input int s);
    int hi;
    int lo;
    int w;
    w = 0;
    hi = 0;
    repeat (100) @(posedge clock);
    if (s == 0) begin
      repeat (60) begin
        @(posedge clock);
        hi += (gp_out !== 1'b0);
      end
      chk("gp off", hi, 32'h0);
    end else begin
      run(1'b1, w, lo);
      run(1'b0, w, lo);
      run(1'b1, w, hi);
      run(1'b0, w, lo);
      chk("gp high", hi, 6 * ((s + 2) / 2));
      chk("gp low", lo, 6 * ((s + 1) / 2));
    end
  endtask : gp_meas

  task automatic exp_chk(input logic [3:0] c, input logic [3:0] l);
    wr(8'h08, {20'h0, l, c, 4'h1});
    repeat (30) @(posedge clock);
    chk("low pins", drive[9:0], 32'h2bc);
    repeat (130) begin
      @(posedge clock);
      chk("marker", drive[11], c < 12 ? !hist[1][c].epoch : 1'b1);
      chk("seq", drive[10], c < 12 ? hist[l + 2][c].chip : 1'b0);
    end
  endtask : exp_chk

  initial begin
    int n;
    int r;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    idle(n, r);
    rd(8'h10);
    chk("status", rv, 32'h10);
    rd(8'h04);
    chk("drive reset", rv, 32'h0);
    rd(8'h14);
    chk("unmapped", rv, 32'h0);
    wr(8'h04, 32'habc);
    repeat (2) @(posedge clock);
    chk("drive pins", drive, 32'habc);
    rd(8'h04);
    chk("drive read", rv, 32'habc);
    sense <= 20'h5a3c1;
    repeat (4) @(posedge clock);
    rd(8'h00);
    n = rv;
    rd(8'h00);
    chk("sense twice", rv, n);
    chk("sense", rv, 32'h5a3c1);
    sense <= 20'ha5c3e;
    repeat (4) @(posedge clock);
    rd(8'h00);
    chk("sense live", rv, 32'ha5c3e);
    exp_chk(4'h0, 4'h0);
    exp_chk(4'hb, 4'hf);
    exp_chk(4'h5, 4'h7);
    exp_chk(4'hc, 4'h3);
    wr(8'h08, 32'h0);
    repeat (4) @(posedge clock);
    chk("export off", drive, 32'habc);
    for (int s = 0; s < 8; s++) begin
      gp_divide_select <= 3'(s);
      gp_meas(s);
    end
    gp_divide_select <= 3'h1;
    wr(8'h08, 32'hc1);
    repeat (20) @(posedge clock);
    wr(8'h0c, 32'h0);
    repeat (8) @(posedge clock);
    wr(8'h04, 32'h0ff);
    idle(n, r);
    chk("soft busy", n + 12 >= 32, 32'h1);
    chk("gp kept", r > 0, 32'h1);
    chk("soft pins", drive, 32'h0);
    rd(8'h04);
    chk("soft clear", rv, 32'h0);
    wr(8'h04, 32'h123);
    @(posedge clock);
    rst <= 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    idle(n, r);
    rd(8'h04);
    chk("hard clear", rv, 32'h0);
    close_out();
  end
endmodule : tb

`default_nettype wire
